// ===== core/asu_pkg.sv
// package: register map, field layout, states and carriers of the channel
package asu_pkg;
  // ==========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_IER = 8'h04;
  localparam logic [7:0] OFF_ISR = 8'h08;
  localparam logic [7:0] OFF_LCR = 8'h0C;
  localparam logic [7:0] OFF_MCR = 8'h10;
  localparam logic [7:0] OFF_LSR = 8'h14;
  localparam logic [7:0] OFF_MSR = 8'h18;
  localparam logic [7:0] OFF_DIV = 8'h1C;
  // ==========================================================
  // field positions
  localparam int IER_RX = 0;
  localparam int IER_THRE = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  localparam int MCR_RTS = 1;
  localparam int MCR_IRQ_OE = 3;
  localparam int LCR_PEN = 3;
  localparam int LCR_EVEN = 4;
  localparam int LCR_STOP = 2;
  localparam int MSR_DCTS = 0;
  localparam int MSR_CTS = 4;
  // ==========================================================
  // reset values
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h03;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0001;
  // ==========================================================
  // isr identification codes
  localparam logic [3:0] ISR_NONE = 4'h1;
  localparam logic [3:0] ISR_LINE = 4'h6;
  localparam logic [3:0] ISR_RXTRG = 4'h4;
  localparam logic [3:0] ISR_RXTMO = 4'hC;
  localparam logic [3:0] ISR_THRE = 4'h2;
  localparam logic [3:0] ISR_MODEM = 4'h0;
  // ==========================================================
  // fifo and timing counts (in 16x oversampling ticks)
  localparam int PTR_W = 4;
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [4:0] RX_TRIG = 5'h0E;
  localparam logic [5:0] TICK_BIT_LAST = 6'h0F;
  localparam logic [5:0] TICK_HALF = 6'h07;
  localparam logic [5:0] TICK_STOP1 = 6'h0F;
  localparam logic [5:0] TICK_STOP15 = 6'h17;
  localparam logic [5:0] TICK_STOP2 = 6'h1F;
  localparam logic [9:0] RX_TMO_TICKS = 10'h280;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // serial state machines
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_PAR = 5'b01000,
    ST_STOP = 5'b10000
  } asu_ser_e;
  // ==========================================================
  // axi4-lite carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } asu_axi_req_s;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asu_axi_rsp_s;
endpackage

// ===== core/asu_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module asu_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic din,
  output logic dout
);
  logic meta_ff;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_ff <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule

// ===== core/asu_uart_top.sv
// serial channel: axi4-lite registers, fifos, transmitter, receiver
// Summary of operation
// - modem status reads 11H when clear-to-send is on and has changed
// - reported clear-to-send change with modem interrupt enabled raises irq
// - each transmit holding write queues a byte unless the queue is full; queued bytes shift out
// - modem control 08H keeps irq output on and releases ready-to-send
// - modem status reads 01H after clear-to-send drops
// - receive interrupt at 14 unread bytes, or fewer with timeout
// - idle transmit line sits at mark, logical 1
// - each character opens with one start bit at 0
// - data bits end with a stop bit at 1
// - data bits per character selectable 5 to 8
// - parity bit goes after last data bit, before stop
// - even or odd parity over data plus parity; none omits it
// - receiver flags a parity error on mismatch
// - stop period 1, 1-1/2 or 2 bit times
// - space longer than a character is a break, not data
// - one bit per baud interval
// - only receive, transmit, ready-to-send and clear-to-send lines
// - ready-to-send and clear-to-send are active low
// - irq reaches host only with modem control bit 3 set
`timescale 1ns/100ps
module asu_uart_top (
  input wire logic clock,
  input wire logic rstn,
  input wire asu_pkg::asu_axi_req_s axi_req,
  output asu_pkg::asu_axi_rsp_s axi_rsp,
  input wire logic rxd,
  output logic txd,
  output logic rts_n,
  input wire logic cts_n,
  output logic host_irq_line_zero_n
);
  import asu_pkg::*;
  // ==========================================================
  // pin synchronisers
  logic rxd_s, cts_n_s;
  asu_sync #(.RST_VAL(1'b1)) u_sync_rxd (
    .clock(clock), .rstn(rstn), .din(rxd), .dout(rxd_s));
  asu_sync #(.RST_VAL(1'b1)) u_sync_cts (
    .clock(clock), .rstn(rstn), .din(cts_n), .dout(cts_n_s));
  // ==========================================================
  // registers and bus state
  logic [7:0] ier_ff, lcr_ff, mcr_ff;
  logic [15:0] div_ff;
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic cts_prev_ff, dcts_ff, irq_n_ff;
  logic perr_ff, ferr_ff, brk_ff, ovr_ff, tmo_ff;
  logic [9:0] tmo_cnt_ff;
  logic [15:0] baud_cnt_ff;
  logic tick_ff;
  // ==========================================================
  // bus decode
  wire wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  wire wr_lane = wstrb_ff[0];
  wire wr_data = wr_go && wr_lane && awaddr_ff == OFF_DATA;
  wire wr_ier = wr_go && wr_lane && awaddr_ff == OFF_IER;
  wire wr_lcr = wr_go && wr_lane && awaddr_ff == OFF_LCR;
  wire wr_mcr = wr_go && wr_lane && awaddr_ff == OFF_MCR;
  wire wr_div = wr_go && awaddr_ff == OFF_DIV;
  wire ar_go = axi_req.arvalid && !rvalid_ff;
  wire rd_data = ar_go && axi_req.araddr == OFF_DATA;
  wire rd_lsr = ar_go && axi_req.araddr == OFF_LSR;
  wire rd_msr = ar_go && axi_req.araddr == OFF_MSR;
  wire wr_mapped = awaddr_ff <= OFF_DIV && awaddr_ff[1:0] == 2'h0;
  wire rd_mapped = axi_req.araddr <= OFF_DIV
    && axi_req.araddr[1:0] == 2'h0;
  // ==========================================================
  // fifos: arrays of 16 bytes each
  logic [7:0] txq_mem [0:15];
  logic [7:0] rxq_mem [0:15];
  logic [PTR_W-1:0] txq_wr_ff, txq_rd_ff, rxq_wr_ff, rxq_rd_ff;
  logic [4:0] txq_cnt_ff, rxq_cnt_ff;
  logic tx_pop, rx_push;
  logic [7:0] rx_byte;
  wire txq_full = txq_cnt_ff == FIFO_DEPTH;
  wire rxq_full = rxq_cnt_ff == FIFO_DEPTH;
  // writes to a full transmit queue are dropped; the host must pace itself
  wire tx_push = wr_data && !txq_full;
  wire rx_pop = rd_data && rxq_cnt_ff != 5'h00;
  wire rx_store = rx_push && !rxq_full;
  wire [4:0] nxt_txq_cnt = txq_cnt_ff + {4'h0, tx_push} - {4'h0, tx_pop};
  wire [4:0] nxt_rxq_cnt = rxq_cnt_ff + {4'h0, rx_store}
    - {4'h0, rx_pop};
  always_ff @(posedge clock)
  begin
    if (tx_push)
      txq_mem[txq_wr_ff] <= wdata_ff[7:0];
    if (rx_store)
      rxq_mem[rxq_wr_ff] <= rx_byte;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      txq_wr_ff <= '0;
      txq_rd_ff <= '0;
      rxq_wr_ff <= '0;
      rxq_rd_ff <= '0;
      txq_cnt_ff <= 5'h00;
      rxq_cnt_ff <= 5'h00;
    end
    else
    begin
      txq_wr_ff <= txq_wr_ff + PTR_W'(tx_push);
      txq_rd_ff <= txq_rd_ff + PTR_W'(tx_pop);
      rxq_wr_ff <= rxq_wr_ff + PTR_W'(rx_store);
      rxq_rd_ff <= rxq_rd_ff + PTR_W'(rx_pop);
      txq_cnt_ff <= nxt_txq_cnt;
      rxq_cnt_ff <= nxt_rxq_cnt;
    end
  end
  // ==========================================================
  // baud generator: 16 ticks per bit, one bit per baud interval
  wire [15:0] div_last = div_ff == 16'h0000 ? 16'h0000 : div_ff - 16'h0001;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      baud_cnt_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= baud_cnt_ff >= div_last;
      baud_cnt_ff <= baud_cnt_ff >= div_last ? 16'h0000
        : baud_cnt_ff + 16'h0001;
    end
  end
  // ==========================================================
  // character format
  wire [2:0] nbits_last = {1'b1, lcr_ff[1:0]}; // 4..7 -> 5..8 bits
  wire [5:0] stop_last = !lcr_ff[LCR_STOP] ? TICK_STOP1
    : lcr_ff[1:0] == 2'h0 ? TICK_STOP15 : TICK_STOP2;
  wire par_on = lcr_ff[LCR_PEN];
  // ==========================================================
  // transmitter
  asu_ser_e tx_st_ff, nxt_tx_st;
  logic [5:0] tx_tk_ff;
  logic [2:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  logic tx_par_ff, txd_ff;
  wire tx_bit_end = tick_ff && tx_tk_ff == TICK_BIT_LAST;
  wire tx_stop_end = tick_ff && tx_tk_ff == stop_last;
  assign tx_pop = tx_st_ff == ST_IDLE && txq_cnt_ff != 5'h00;
  always_comb
  begin
    nxt_tx_st = tx_st_ff;
    case (tx_st_ff)
      ST_IDLE: if (tx_pop) nxt_tx_st = ST_START;
      ST_START: if (tx_bit_end) nxt_tx_st = ST_DATA;
      ST_DATA:
        if (tx_bit_end && tx_bit_ff == nbits_last)
          nxt_tx_st = par_on ? ST_PAR : ST_STOP;
      ST_PAR: if (tx_bit_end) nxt_tx_st = ST_STOP;
      ST_STOP: if (tx_stop_end) nxt_tx_st = ST_IDLE;
      default: nxt_tx_st = ST_IDLE;
    endcase
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_st_ff <= ST_IDLE;
      tx_tk_ff <= 6'h00;
      tx_bit_ff <= 3'h0;
      tx_sh_ff <= 8'h00;
      tx_par_ff <= 1'b0;
      txd_ff <= 1'b1;
    end
    else
    begin
      tx_st_ff <= nxt_tx_st;
      // restart the tick count at every data bit edge too, not only on
      // state changes, or the next bit would run until the counter wraps
      if (tx_pop || nxt_tx_st != tx_st_ff
        || (tx_st_ff == ST_DATA && tx_bit_end))
        tx_tk_ff <= 6'h00;
      else if (tick_ff)
        tx_tk_ff <= tx_tk_ff + 6'h01;
      if (tx_pop)
      begin
        tx_sh_ff <= txq_mem[txq_rd_ff];
        tx_bit_ff <= 3'h0;
        tx_par_ff <= !lcr_ff[LCR_EVEN]; // odd starts at 1
      end
      else if (tx_st_ff == ST_DATA && tx_bit_end)
      begin
        tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
        tx_bit_ff <= tx_bit_ff + 3'h1;
        tx_par_ff <= tx_par_ff ^ tx_sh_ff[0];
      end
      case (tx_st_ff)
        ST_START: txd_ff <= 1'b0;
        ST_DATA: txd_ff <= tx_sh_ff[0];
        ST_PAR: txd_ff <= tx_par_ff;
        ST_STOP: txd_ff <= 1'b1;
        default: txd_ff <= 1'b1;
      endcase
    end
  end
  // ==========================================================
  // receiver
  asu_ser_e rx_st_ff;
  logic [5:0] rx_tk_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_par_ff, rx_brk_wait_ff;
  wire rx_mid = tick_ff && rx_tk_ff == TICK_BIT_LAST;
  wire rx_stop_mid = rx_st_ff == ST_STOP && rx_mid;
  // all-space character with space stop bit is a break, never data
  wire rx_is_brk = rx_stop_mid && !rxd_s && rx_sh_ff == 8'h00
    && !rx_par_ff; // all-zero data, so this is the parity bit
  assign rx_push = rx_stop_mid && !rx_is_brk;
  assign rx_byte = rx_sh_ff >> (3'h7 - nbits_last);
  // running xor over data and parity ends at 0 for even, 1 for odd
  wire rx_perr = par_on && rx_par_ff == lcr_ff[LCR_EVEN];
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_st_ff <= ST_IDLE;
      rx_tk_ff <= 6'h00;
      rx_bit_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      rx_par_ff <= 1'b0;
      rx_brk_wait_ff <= 1'b0;
    end
    else
    begin
      if (rx_mid)
        rx_tk_ff <= 6'h00;
      else if (tick_ff)
        rx_tk_ff <= rx_tk_ff + 6'h01;
      case (rx_st_ff)
        ST_IDLE:
          if (rx_brk_wait_ff)
            rx_brk_wait_ff <= !rxd_s;
          else if (tick_ff && !rxd_s)
          begin
            rx_st_ff <= ST_START;
            rx_tk_ff <= 6'h00;
          end
        ST_START:
          if (tick_ff && rx_tk_ff == TICK_HALF)
          begin
            // re-phase so later samples land mid-bit
            rx_st_ff <= rxd_s ? ST_IDLE : ST_DATA;
            rx_tk_ff <= 6'h00;
            rx_bit_ff <= 3'h0;
            rx_par_ff <= 1'b0;
          end
        ST_DATA:
          if (rx_mid)
          begin
            rx_sh_ff <= {rxd_s, rx_sh_ff[7:1]};
            rx_par_ff <= rx_par_ff ^ rxd_s;
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == nbits_last)
              rx_st_ff <= par_on ? ST_PAR : ST_STOP;
          end
        ST_PAR:
          if (rx_mid)
          begin
            rx_par_ff <= rx_par_ff ^ rxd_s;
            rx_st_ff <= ST_STOP;
          end
        default:
          if (rx_mid)
          begin
            rx_st_ff <= ST_IDLE;
            rx_brk_wait_ff <= rx_is_brk;
          end
      endcase
      if (rx_st_ff == ST_START && tick_ff && rx_tk_ff == TICK_HALF)
        rx_sh_ff <= 8'h00;
    end
  end
  // ==========================================================
  // line status flags: hardware set wins over read clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      perr_ff <= 1'b0;
      ferr_ff <= 1'b0;
      brk_ff <= 1'b0;
      ovr_ff <= 1'b0;
      tmo_ff <= 1'b0;
      tmo_cnt_ff <= 10'h000;
    end
    else
    begin
      perr_ff <= (rx_push && rx_perr) || (perr_ff && !rd_lsr);
      ferr_ff <= (rx_push && !rxd_s) || (ferr_ff && !rd_lsr);
      brk_ff <= rx_is_brk || (brk_ff && !rd_lsr);
      ovr_ff <= (rx_push && rxq_full) || (ovr_ff && !rd_lsr);
      if (rx_store || rx_pop || rxq_cnt_ff == 5'h00)
        tmo_cnt_ff <= 10'h000;
      else if (tick_ff && tmo_cnt_ff != RX_TMO_TICKS)
        tmo_cnt_ff <= tmo_cnt_ff + 10'h001;
      tmo_ff <= tmo_cnt_ff == RX_TMO_TICKS;
    end
  end
  // ==========================================================
  // modem status and interrupt line
  wire cts_on = !cts_n_s;
  wire cts_chg = cts_on != cts_prev_ff;
  wire line_err = perr_ff || ferr_ff || brk_ff || ovr_ff;
  wire rx_trg = rxq_cnt_ff >= RX_TRIG;
  wire [3:0] isr_id = ier_ff[IER_LINE] && line_err ? ISR_LINE
    : ier_ff[IER_RX] && rx_trg ? ISR_RXTRG
    : ier_ff[IER_RX] && tmo_ff ? ISR_RXTMO
    : ier_ff[IER_THRE] && txq_cnt_ff == 5'h00 ? ISR_THRE
    : ier_ff[IER_MODEM] && dcts_ff ? ISR_MODEM : ISR_NONE;
  wire irq_any = isr_id != ISR_NONE;
  wire [7:0] msr_val = {3'h0, cts_on, 3'h0, dcts_ff};
  wire [7:0] lsr_val = {1'b0, tx_st_ff == ST_IDLE && txq_cnt_ff == 5'h00,
    txq_cnt_ff == 5'h00, brk_ff, ferr_ff, perr_ff, ovr_ff,
    rxq_cnt_ff != 5'h00};
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cts_prev_ff <= 1'b0;
      dcts_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end
    else
    begin
      cts_prev_ff <= cts_on;
      dcts_ff <= cts_chg || (dcts_ff && !rd_msr);
      irq_n_ff <= !(mcr_ff[MCR_IRQ_OE] && irq_any);
    end
  end
  // ==========================================================
  // read data mux
  wire [7:0] rd_val = axi_req.araddr == OFF_DATA ? rxq_mem[rxq_rd_ff]
    : axi_req.araddr == OFF_IER ? ier_ff
    : axi_req.araddr == OFF_ISR ? {4'h0, isr_id}
    : axi_req.araddr == OFF_LCR ? lcr_ff
    : axi_req.araddr == OFF_MCR ? mcr_ff
    : axi_req.araddr == OFF_LSR ? lsr_val
    : axi_req.araddr == OFF_MSR ? msr_val : 8'h00;
  wire [31:0] rd_word = axi_req.araddr == OFF_DIV ? {16'h0000, div_ff}
    : rd_data && rxq_cnt_ff == 5'h00 ? 32'h0000_0000 : {24'h0, rd_val};
  // ==========================================================
  // axi4-lite slave and control registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bresp_ff <= RESP_OKAY;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      ier_ff <= IER_RST;
      lcr_ff <= LCR_RST;
      mcr_ff <= MCR_RST;
      div_ff <= DIV_RST;
    end
    else
    begin
      if (axi_req.awvalid && !aw_got_ff)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= axi_req.awaddr;
      end
      if (axi_req.wvalid && !w_got_ff)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= axi_req.wdata;
        wstrb_ff <= axi_req.wstrb;
      end
      if (wr_go)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_ff && axi_req.bready)
      begin
        bvalid_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
      if (ar_go)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mapped ? rd_word : 32'h0000_0000;
        rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff && axi_req.rready)
        rvalid_ff <= 1'b0;
      if (wr_ier)
        ier_ff <= {4'h0, wdata_ff[3:0]};
      if (wr_lcr)
        lcr_ff <= wdata_ff[7:0];
      if (wr_mcr)
        mcr_ff <= wdata_ff[7:0];
      if (wr_div && wstrb_ff[0])
        div_ff[7:0] <= wdata_ff[7:0];
      if (wr_div && wstrb_ff[1])
        div_ff[15:8] <= wdata_ff[15:8];
    end
  end
  // ==========================================================
  // outputs
  assign axi_rsp.awready = !aw_got_ff;
  assign axi_rsp.wready = !w_got_ff;
  assign axi_rsp.bvalid = bvalid_ff;
  assign axi_rsp.bresp = bresp_ff;
  assign axi_rsp.arready = !rvalid_ff;
  assign axi_rsp.rvalid = rvalid_ff;
  assign axi_rsp.rdata = rdata_ff;
  assign axi_rsp.rresp = rresp_ff;
  assign txd = txd_ff;
  // only four signal lines exist; ready-to-send driven low when on
  assign rts_n = !mcr_ff[MCR_RTS];
  assign host_irq_line_zero_n = irq_n_ff;
  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_cts_change_flag: assert property (cts_chg |=> dcts_ff)
    else $error("cts change not flagged");
  a_msr_read_value: assert property (rd_msr && dcts_ff
    |=> rdata_ff[7:0] == {3'h0, $past(cts_on), 4'h1})
    else $error("modem status read value wrong");
  a_msr_read_clear: assert property (rd_msr && !cts_chg |=> !dcts_ff)
    else $error("modem status change flag not cleared");
  a_modem_irq_raise: assert property (mcr_ff[MCR_IRQ_OE]
    && ier_ff[IER_MODEM] && dcts_ff |=> !host_irq_line_zero_n)
    else $error("modem interrupt missing");
  a_irq_output_gate: assert property (!$past(mcr_ff[MCR_IRQ_OE])
    |-> host_irq_line_zero_n)
    else $error("irq with output enable clear");
  a_mcr_rts_release: assert property (wr_mcr && wdata_ff[7:0] == 8'h08
    |=> rts_n && mcr_ff[MCR_IRQ_OE])
    else $error("ready-to-send not released");
  a_rx_trig_irq: assert property (rx_trg && ier_ff[IER_RX]
    && mcr_ff[MCR_IRQ_OE] |=> !host_irq_line_zero_n)
    else $error("receive trigger interrupt missing");
  a_tx_idle_mark: assert property (tx_st_ff == ST_IDLE
    && $past(tx_st_ff == ST_IDLE) |=> txd)
    else $error("idle line not at mark");
  a_tx_start_space: assert property (tx_st_ff == ST_START |=> !txd)
    else $error("start bit not space");
  a_tx_stop_mark: assert property (tx_st_ff == ST_STOP |=> txd)
    else $error("stop bit not mark");
  a_brk_no_data: assert property (rx_is_brk |=> rxq_cnt_ff
    == $past(rxq_cnt_ff) - {4'h0, $past(rx_pop)})
    else $error("break stored as data");
  c_tx_char: cover property (tx_st_ff == ST_STOP ##1 tx_st_ff == ST_IDLE);
  c_rx_char: cover property (rx_store);
  c_rx_break: cover property (rx_is_brk);
  c_cts_irq: cover property (dcts_ff && !host_irq_line_zero_n);
endmodule

// ===== testbench/asu_remote.sv
// remote terminal model: drives receive data and clear-to-send
`timescale 1ns/100ps
module asu_remote (
  input wire logic clock,
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd,
  output logic cts_n
);
  initial
  begin
    rxd = 1'b1;
    cts_n = 1'b1;
  end
  // ==========================================================
  // clear-to-send answers ready-to-send after a short turnaround
  always @(rts_n)
  begin
    repeat (5) @(posedge clock);
    cts_n <= rts_n;
  end
  // ==========================================================
  // frame out on the receive line, 16 clocks a bit, back to mark
  task send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd <= f[i];
      repeat (16) @(posedge clock);
    end
    rxd <= 1'b1;
    @(posedge clock);
  endtask
  // ==========================================================
  // sample a transmitted frame mid-bit; unsampled bits read as mark
  task grab(output logic [11:0] f, output time t, input int n);
    f = 12'hFFF;
    @(negedge txd);
    t = $time;
    for (int i = 0; i < n; i++)
    begin
      repeat (i == 0 ? 8 : 16) @(posedge clock);
      f[i] = txd;
    end
  endtask
endmodule

// ===== testbench/async_serial_uart_channel_test.sv
// testbench: registers, framing both ways, modem lines, receive irq
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t %h %h", $time, (a), (b)); end end
module async_serial_uart_channel_test;
  import asu_pkg::*;
  logic clock;
  logic rstn;
  asu_axi_req_s req;
  asu_axi_rsp_s rsp;
  logic rxd, txd, rts_n, cts_n, irq_n;
  int errors, n_compared, n, dt;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [11:0] f, g;
  logic [7:0] c, d;
  time t0, t1;
  // lcr, data written, data the receiver should return
  logic [23:0] rows [6] = '{24'h00F515, 24'h04EA0A, 24'h0DAB2B,
    24'h1AD555, 24'h1FC3C3, 24'h0B8080};

  asu_uart_top u_asu_uart_top (.clock(clock), .rstn(rstn), .axi_req(req),
    .axi_rsp(rsp), .rxd(rxd), .txd(txd), .rts_n(rts_n), .cts_n(cts_n),
    .host_irq_line_zero_n(irq_n));
  asu_remote u_asu_remote (.clock(clock), .txd(txd), .rts_n(rts_n),
    .rxd(rxd), .cts_n(cts_n));

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ==========================================================
  // expected frame, start bit first, stop and idle bits at mark
  function automatic logic [11:0] frame(input logic [7:0] c, d);
    logic p;
    frame = 12'hFFF;
    frame[0] = 1'b0;
    p = ~c[4];
    for (int i = 0; i < 5 + c[1:0]; i++)
    begin
      frame[i + 1] = d[i];
      p ^= d[i];
    end
    if (c[3])
      frame[6 + c[1:0]] = p;
  endfunction
  // ==========================================================
  // axi4-lite master; address and data released as each is taken
  task wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clock);
    req.awaddr <= a;
    req.wdata <= w;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge clock);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    while (!rsp.rvalid);
    r = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task complete_run;
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // watchdog: whole run needs well under 15000 clocks
  initial
  begin
    repeat (40000) @(posedge clock);
    errors++;
    complete_run();
  end
  // ==========================================================
  initial
  begin
    req = '0;
    rstn = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    `CHK({txd, rts_n, irq_n}, 3'b111)
    rd(OFF_LCR, rv);
    `CHK(rv[7:0], LCR_RST)
    rd(8'h20, rv);
    `CHK({rr, rv}, {RESP_SLVERR, 32'h0})
    wr(8'h06, 32'h0F);
    `CHK(rr, RESP_SLVERR)
    wr(OFF_IER, 32'h08);
    `CHK(rr, RESP_OKAY)
    wr(OFF_MCR, 32'h02);
    repeat (10) @(posedge clock);
    `CHK({rts_n, irq_n}, 2'b01)
    wr(OFF_MCR, 32'h0A);
    repeat (3) @(posedge clock);
    `CHK(irq_n, 1'b0)
    rd(OFF_MSR, rv);
    `CHK(rv[7:0], 8'h11)
    repeat (2) @(posedge clock);
    `CHK(irq_n, 1'b1)
    for (int k = 0; k < 6; k++)
    begin
      c = rows[k][23:16];
      d = rows[k][15:8];
      n = 7 + c[1:0] + c[3];
      wr(OFF_LCR, {24'h0, c});
      rd(OFF_MSR, rv);
      `CHK(rv[4], 1'b1)
      fork
        begin
          u_asu_remote.grab(f, t0, n);
          u_asu_remote.grab(g, t1, n);
        end
        begin
          wr(OFF_DATA, {24'h0, d});
          wr(OFF_DATA, {24'h0, d});
        end
      join
      `CHK({f, g}, {2{frame(c, d)}})
      dt = int'((t1 - t0) / 50) - 16 * (n - 1);
      dt -= c[2] ? (c[1:0] == 2'h0 ? 24 : 32) : 16;
      `CHK(dt inside {[-1:2]}, 1'b1)
      u_asu_remote.send(frame(c, d), n);
      rd(OFF_DATA, rv);
      `CHK(rv[7:0], rows[k][7:0])
    end
    wr(OFF_MCR, 32'h08);
    repeat (8) @(posedge clock);
    `CHK(rts_n, 1'b1)
    rd(OFF_MSR, rv);
    `CHK(rv[7:0], 8'h01)
    wr(OFF_LCR, 32'h1B);
    u_asu_remote.send(frame(8'h1B, 8'h5A) ^ 12'h200, 11);
    rd(OFF_LSR, rv);
    `CHK(rv[2], 1'b1)
    rd(OFF_DATA, rv);
    u_asu_remote.send(12'h000, 12);
    rd(OFF_LSR, rv);
    `CHK({rv[4], rv[0]}, 2'b10)
    wr(OFF_IER, 32'h01);
    wr(OFF_LCR, 32'h03);
    for (int k = 0; k < 13; k++)
      u_asu_remote.send(frame(8'h03, 8'(k)), 10);
    `CHK(irq_n, 1'b1)
    repeat (700) @(posedge clock);
    rd(OFF_ISR, rv);
    `CHK(rv[3:0], ISR_RXTMO)
    u_asu_remote.send(frame(8'h03, 8'hEE), 10);
    repeat (4) @(posedge clock);
    `CHK(irq_n, 1'b0)
    rd(OFF_ISR, rv);
    `CHK(rv[3:0], ISR_RXTRG)
    rstn <= 1'b0;
    @(posedge clock);
    `CHK({txd, rts_n, irq_n}, 3'b111)
    rstn <= 1'b1;
    rd(OFF_ISR, rv);
    `CHK(rv[3:0], ISR_NONE)
    complete_run();
  end
endmodule
